//--- rtl/hsga_regs.vh
// Overview of operation
// - Shared memory is reached only as whole 16-bit words.
// - Engine wins the shared memory; a host cycle waits until the engine finishes.
// - Shared memory fills memory offsets 0 to 1FFFF, read/write, data bits 0-15.
// - Read-only jumper status at offsets 42-43, only bits 0-7 meaningful.
// - Status bits 0 and 1 show the two mode-select inputs; bits 4-7 unused.
// - Mode pair high/low: 00 controller, 01 terminal, 10 monitor, 11 both.
// - Status bit 2 reads the inverse of the configuration-lock input.
// - Lock input captured on master reset rising edge and held until the next edge or a reset, which clears it.
// - Status bit 3 reads the inverse of engine ready, held at zero while reset is held.
// - The two engine interrupts are ORed onto the single host request line.
// - Interrupt acknowledge returns the engine vector on data bits 0-7.
// - Each engine interrupt pulses three clocks per enabled event.
// - Swap jumper shorted swaps bytes of memory and register data; open passes.
// - While locked, software writes to address, standard and mode are blocked.
// - Terminal address comes from five jumper bits plus a parity jumper.
// - A jumper standard-select chooses 1553A or 1553B behaviour.
// - An engine interrupt writes host inbox register four.
// - Memory answers in region 3 (0-1FFFF); registers in region 1 (0-7F).
`ifndef HSGA_REGS_VH
`define HSGA_REGS_VH
`define HSGA_MEM_LAST 17'h1FFFF
`define HSGA_ENG_REG_LAST 7'h3F
`define HSGA_ENG_CTRL_OFS 7'h00
`define HSGA_STATUS_OFS 7'h42
`define HSGA_REG_LAST 7'h7F
`define HSGA_STATUS_RESET 16'h0000
`define HSGA_ST_MSEL_LO 0
`define HSGA_ST_MSEL_HI 1
`define HSGA_ST_LOCK 2
`define HSGA_ST_READY 3
`define HSGA_MODE_BC 2'h0
`define HSGA_MODE_RT 2'h1
`define HSGA_MODE_MON 2'h2
`define HSGA_MODE_MONRT 2'h3
`define HSGA_IRQ_PULSE_CYC 3
`endif

//--- rtl/hsga_swap.v
`timescale 1ns/1ps
module hsga_swap #(
	parameter W = 16
) (
	swap_en,
	din,
	dout
);
	input wire swap_en;
	input wire [W-1:0] din;
	output wire [W-1:0] dout;

	assign dout = swap_en ? {din[W/2-1:0], din[W-1:W/2]} : din;
endmodule // hsga_swap

//--- rtl/hsga_top.v
`timescale 1ns/1ps
`include "hsga_regs.vh"
module hsga_top #(
	parameter MEM_AW = 16,
	parameter DW = 16
) (
	input wire mclk,
	input wire reset,
	input wire master_reset_in,
	input wire lb_mem_sel,
	input wire lb_reg_sel,
	input wire lb_rd,
	input wire lb_wr,
	input wire lb_intack,
	input wire [16:0] lb_addr,
	input wire [DW-1:0] lb_wdata,
	output reg [DW-1:0] lb_rdata,
	output reg lb_ready,
	input wire eng_mem_req,
	input wire eng_mem_we,
	input wire [MEM_AW-1:0] eng_mem_addr,
	input wire [DW-1:0] eng_mem_wdata,
	output reg [DW-1:0] eng_mem_rdata,
	output reg eng_mem_done,
	output reg [MEM_AW-1:0] sram_addr,
	output reg [DW-1:0] sram_wdata,
	input wire [DW-1:0] sram_rdata,
	output reg sram_ce,
	output reg sram_we,
	output reg [4:0] ereg_addr,
	output reg [DW-1:0] ereg_wdata,
	output reg ereg_rd,
	output reg ereg_wr,
	input wire [DW-1:0] ereg_rdata,
	input wire [7:0] eng_vector,
	input wire engine_ready,
	input wire message_irq,
	input wire terminal_fail_irq,
	output reg host_irq_line,
	output reg host_inbox_four_wr,
	output reg [7:0] host_inbox_four_data,
	input wire mode_select_low,
	input wire mode_select_high,
	input wire cfg_lock_pin,
	input wire swap_jumper,
	input wire rt_addr_bit0,
	input wire rt_addr_bit1,
	input wire rt_addr_bit2,
	input wire rt_addr_bit3,
	input wire rt_addr_bit4,
	input wire rt_addr_parity,
	input wire standard_version_select,
	output reg bus_controller_mode,
	output reg remote_terminal_mode,
	output reg monitor_mode,
	output reg [4:0] rt_addr_out,
	output reg rt_parity_out,
	output reg std_1553b_out
);
	localparam S_IDLE = 5'h01;
	localparam S_ENG = 5'h02;
	localparam S_HMEM = 5'h04;
	localparam S_HREG = 5'h08;
	localparam S_ACK = 5'h10;

	reg [4:0] state_q;
	reg [4:0] state_d;
	reg master_reset_in_prev_q;
	reg lock_q;
	reg [1:0] mode_q;
	reg irq_prev_q;
	reg reg_status_q;
	wire host_mem_req;
	wire host_reg_req;
	wire mem_hit;
	wire eng_reg_hit;
	wire status_hit;
	wire ctrl_write_blocked;
	wire irq_any;
	wire [DW-1:0] wdata_sw;
	wire [DW-1:0] sram_rd_sw;
	wire [DW-1:0] ereg_rd_sw;
	wire [DW-1:0] status_sw;
	wire [DW-1:0] status_word;

	// Byte lanes swap only when the jumper is shorted
	hsga_swap #(.W(DW)) u_swap_wr (
		.swap_en(swap_jumper),
		.din(lb_wdata),
		.dout(wdata_sw)
	);
	hsga_swap #(.W(DW)) u_swap_mem (
		.swap_en(swap_jumper),
		.din(sram_rdata),
		.dout(sram_rd_sw)
	);
	hsga_swap #(.W(DW)) u_swap_reg (
		.swap_en(swap_jumper),
		.din(ereg_rdata),
		.dout(ereg_rd_sw)
	);
	hsga_swap #(.W(DW)) u_swap_st (
		.swap_en(swap_jumper),
		.din(status_word),
		.dout(status_sw)
	);

	// Whole words only: address bit 0 is ignored, no byte strobes exist
	assign mem_hit = (lb_addr <= `HSGA_MEM_LAST);
	assign eng_reg_hit = (lb_addr[6:0] <= `HSGA_ENG_REG_LAST);
	assign status_hit = ({lb_addr[6:1], 1'b0} == `HSGA_STATUS_OFS);
	assign host_mem_req = lb_mem_sel & (lb_rd | lb_wr) & mem_hit;
	assign host_reg_req = lb_reg_sel & (lb_rd | lb_wr | lb_intack);
	assign ctrl_write_blocked = lock_q & ({lb_addr[6:1], 1'b0} == `HSGA_ENG_CTRL_OFS);
	assign irq_any = message_irq | terminal_fail_irq;

	// Upper byte and bits 4-7 are zero before the byte swap
	assign status_word = {{(DW-4){1'b0}},
		~engine_ready & reg_status_q,
		~lock_q,
		mode_q[1],
		mode_q[0]};

	// Jumper-fed settings move only on reset or on a master reset rising edge
	always @(posedge mclk)
	begin
		if (reset)
		begin
			master_reset_in_prev_q <= 1'b0;
			lock_q <= 1'b0;
			mode_q <= `HSGA_MODE_BC;
			rt_addr_out <= 5'h00;
			rt_parity_out <= 1'b0;
			std_1553b_out <= 1'b0;
			reg_status_q <= 1'b0;
		end
		else
		begin
			master_reset_in_prev_q <= master_reset_in;
			// Not-ready is reported only once reset has let go of the status
			reg_status_q <= 1'b1;
			if (master_reset_in & ~master_reset_in_prev_q)
			begin
				lock_q <= cfg_lock_pin;
				mode_q <= {mode_select_high, mode_select_low};
				rt_addr_out <= {rt_addr_bit4, rt_addr_bit3, rt_addr_bit2,
					rt_addr_bit1, rt_addr_bit0};
				rt_parity_out <= rt_addr_parity;
				std_1553b_out <= standard_version_select;
			end
		end
	end

	always @(posedge mclk)
	begin
		if (reset)
		begin
			bus_controller_mode <= 1'b1;
			remote_terminal_mode <= 1'b0;
			monitor_mode <= 1'b0;
		end
		else
		begin
			case (mode_q)
				`HSGA_MODE_BC:
				begin
					bus_controller_mode <= 1'b1;
					remote_terminal_mode <= 1'b0;
					monitor_mode <= 1'b0;
				end
				`HSGA_MODE_RT:
				begin
					bus_controller_mode <= 1'b0;
					remote_terminal_mode <= 1'b1;
					monitor_mode <= 1'b0;
				end
				`HSGA_MODE_MON:
				begin
					bus_controller_mode <= 1'b0;
					remote_terminal_mode <= 1'b0;
					monitor_mode <= 1'b1;
				end
				default:
				begin
					bus_controller_mode <= 1'b0;
					remote_terminal_mode <= 1'b1;
					monitor_mode <= 1'b1;
				end
			endcase
		end
	end

	// The engine already stretches each event to three clocks; one flop keeps the width
	always @(posedge mclk)
	begin
		if (reset)
		begin
			host_irq_line <= 1'b0;
			irq_prev_q <= 1'b0;
			host_inbox_four_wr <= 1'b0;
			host_inbox_four_data <= 8'h00;
		end
		else
		begin
			host_irq_line <= irq_any;
			irq_prev_q <= irq_any;
			host_inbox_four_wr <= irq_any & ~irq_prev_q;
			if (irq_any & ~irq_prev_q)
				host_inbox_four_data <= eng_vector;
		end
	end

	always @*
	begin
		state_d = state_q;
		case (state_q)
			S_IDLE:
			begin
				// Engine checked first so a waiting host cycle never overtakes it
				if (eng_mem_req)
					state_d = S_ENG;
				else if (host_mem_req)
					state_d = S_HMEM;
				else if (host_reg_req)
					state_d = S_HREG;
			end
			S_ENG: state_d = S_IDLE;
			S_HMEM: state_d = S_ACK;
			S_HREG: state_d = S_ACK;
			S_ACK: state_d = S_IDLE;
			default: state_d = S_IDLE;
		endcase
	end

	always @(posedge mclk)
	begin
		if (reset)
		begin
			state_q <= S_IDLE;
			sram_addr <= {MEM_AW{1'b0}};
			sram_wdata <= {DW{1'b0}};
			sram_ce <= 1'b0;
			sram_we <= 1'b0;
			eng_mem_rdata <= {DW{1'b0}};
			eng_mem_done <= 1'b0;
			ereg_addr <= 5'h00;
			ereg_wdata <= {DW{1'b0}};
			ereg_rd <= 1'b0;
			ereg_wr <= 1'b0;
			lb_rdata <= {DW{1'b0}};
			lb_ready <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			sram_ce <= 1'b0;
			sram_we <= 1'b0;
			eng_mem_done <= 1'b0;
			ereg_rd <= 1'b0;
			ereg_wr <= 1'b0;
			lb_ready <= 1'b0;
			case (state_q)
				S_IDLE:
				begin
					if (eng_mem_req)
					begin
						sram_ce <= 1'b1;
						sram_we <= eng_mem_we;
						sram_addr <= eng_mem_addr;
						sram_wdata <= eng_mem_wdata;
					end
					else if (host_mem_req)
					begin
						sram_ce <= 1'b1;
						sram_we <= lb_wr;
						sram_addr <= lb_addr[MEM_AW:1];
						sram_wdata <= wdata_sw;
					end
					else if (host_reg_req & ~lb_intack & eng_reg_hit)
					begin
						ereg_addr <= lb_addr[5:1];
						ereg_wdata <= wdata_sw;
						ereg_rd <= lb_rd;
						ereg_wr <= lb_wr & ~ctrl_write_blocked;
					end
				end
				S_ENG:
				begin
					eng_mem_rdata <= sram_rdata;
					eng_mem_done <= 1'b1;
				end
				S_HMEM:
				begin
					lb_rdata <= sram_rd_sw;
					lb_ready <= 1'b1;
				end
				S_HREG:
				begin
					lb_ready <= 1'b1;
					if (lb_intack)
						lb_rdata <= {{(DW-8){1'b0}}, eng_vector};
					else if (eng_reg_hit)
						lb_rdata <= ereg_rd_sw;
					else if (status_hit)
						lb_rdata <= status_sw;
					else
						lb_rdata <= {DW{1'b0}};
				end
				S_ACK:
				begin
				end
				default:
				begin
				end
			endcase
		end
	end
endmodule // hsga_top

//--- bench/hsga_props.sv
`timescale 1ns/1ps
module hsga_props (
	input wire mclk,
	input wire reset,
	input wire master_reset_in,
	input wire lb_intack,
	input wire [15:0] lb_rdata,
	input wire lb_ready,
	input wire eng_mem_req,
	input wire eng_mem_done,
	input wire sram_ce,
	input wire [7:0] eng_vector,
	input wire message_irq,
	input wire terminal_fail_irq,
	input wire host_irq_line,
	input wire host_inbox_four_wr,
	input wire [7:0] host_inbox_four_data,
	input wire bus_controller_mode,
	input wire remote_terminal_mode,
	input wire monitor_mode
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (reset);
	sequence s_quiet;
		$stable(master_reset_in) [*3];
	endsequence
	sequence s_pulse;
		host_irq_line [*3] ##1 !host_irq_line;
	endsequence
	a_irq_merge: assert property (host_irq_line == $past(message_irq | terminal_fail_irq))
		else $error("irq merge");
	a_irq_three: assert property ($rose(host_irq_line) |-> s_pulse)
		else $error("irq width");
	a_inbox_rise: assert property ($rose(message_irq | terminal_fail_irq) |=> host_inbox_four_wr)
		else $error("inbox write");
	a_inbox_vec: assert property (host_inbox_four_wr |-> host_inbox_four_data == $past(eng_vector))
		else $error("inbox data");
	a_engine_first: assert property ($rose(eng_mem_req) |-> ##[1:6] eng_mem_done)
		else $error("engine wait");
	a_sram_answer: assert property (sram_ce |=> lb_ready ^ eng_mem_done)
		else $error("sram owner");
	a_mode_hold: assert property (s_quiet |-> $stable({bus_controller_mode, monitor_mode}))
		else $error("mode drift");
	a_vector_read: assert property (lb_ready && $past(lb_intack) |-> lb_rdata[7:0] == eng_vector)
		else $error("vector");
	a_mode_rt: assert property (s_quiet |-> $stable(remote_terminal_mode))
		else $error("rt drift");
endmodule // hsga_props

bind hsga_top hsga_props i_hsga_props (.*);

//--- bench/hsga_far.sv
`timescale 1ns/1ps
module hsga_far (
	input wire mclk,
	input wire [15:0] sram_addr,
	input wire [15:0] sram_wdata,
	input wire sram_ce,
	input wire sram_we,
	output wire [15:0] sram_rdata,
	input wire [4:0] ereg_addr,
	input wire [15:0] ereg_wdata,
	input wire ereg_rd,
	input wire ereg_wr,
	output wire [15:0] ereg_rdata
);
	reg [15:0] mem [0:65535];
	reg [15:0] regs [0:31];
	reg [15:0] last_q;
	// Idle data bus shows the inverted last word, so a late sample cannot pass
	assign sram_rdata = sram_ce ? mem[sram_addr] : ~last_q;
	// Register data is only good while the read strobe stands
	assign ereg_rdata = ereg_rd ? regs[ereg_addr] : ~regs[ereg_addr];
	always @(posedge mclk)
	begin
		if (sram_ce)
			last_q <= mem[sram_addr];
		if (sram_ce & sram_we)
			mem[sram_addr] <= sram_wdata;
		if (ereg_wr)
			regs[ereg_addr] <= ereg_wdata;
	end
endmodule // hsga_far

//--- bench/tb_host_side_glue_arbiter.sv
`timescale 1ns/1ps
module tb_host_side_glue_arbiter;
	reg mclk = 1'b0, reset = 1'b1, master_reset_in = 1'b0, lb_mem_sel = 1'b0, lb_reg_sel = 1'b0;
	reg lb_rd = 1'b0, lb_wr = 1'b0, lb_intack = 1'b0, eng_mem_req = 1'b0, eng_mem_we = 1'b0;
	reg engine_ready = 1'b1, message_irq = 1'b0, terminal_fail_irq = 1'b0, swap_jumper = 1'b0;
	reg [16:0] lb_addr = 17'h00000;
	reg [15:0] lb_wdata = 16'h0000, eng_mem_addr = 16'h0000, eng_mem_wdata = 16'h0000, got;
	reg [15:0] irq_n = 16'h0000, ibx_n = 16'h0000;
	reg [7:0] eng_vector = 8'h5C;
	reg [4:0] rta = 5'h00, cfg = 5'h00;
	reg [51:0] rows [0:7];
	integer n_errors = 0, cmp_count = 0, i;
	wire rt_addr_bit0 = rta[0], rt_addr_bit1 = rta[1], rt_addr_bit2 = rta[2];
	wire rt_addr_bit3 = rta[3], rt_addr_bit4 = rta[4], rt_addr_parity = cfg[3];
	wire mode_select_low = cfg[0], mode_select_high = cfg[1], cfg_lock_pin = cfg[2];
	wire standard_version_select = cfg[4];
	wire [15:0] lb_rdata, eng_mem_rdata, sram_addr, sram_wdata, sram_rdata, ereg_wdata, ereg_rdata;
	wire [7:0] host_inbox_four_data;
	wire [4:0] ereg_addr, rt_addr_out;
	wire lb_ready, eng_mem_done, sram_ce, sram_we, ereg_rd, ereg_wr, host_irq_line;
	wire host_inbox_four_wr, bus_controller_mode, remote_terminal_mode, monitor_mode;
	wire rt_parity_out, std_1553b_out;
	wire [2:0] md = {bus_controller_mode, remote_terminal_mode, monitor_mode};
	wire [6:0] rtv = {std_1553b_out, rt_parity_out, rt_addr_out};
	hsga_top i_hsga_top (.*);
	hsga_far i_hsga_far (.*);
	always #12.5 mclk = ~mclk;
	// Counting waits for reset, else the unknown outputs at time zero poison the sums
	always @(posedge mclk)
	begin
		if (!reset)
		begin
			irq_n <= irq_n + {15'h0000, host_irq_line};
			ibx_n <= ibx_n + {15'h0000, host_inbox_four_wr};
		end
	end
	task chk(input string nm, input [15:0] e, input [15:0] g);
	begin
		cmp_count = cmp_count + 1;
		if (g !== e)
		begin
			n_errors = n_errors + 1;
			$display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
		end
	end
	endtask
	task tally_and_finish(input hung);
	begin
		if (hung)
			n_errors = n_errors + 1;
		$display("compares %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask
	// Bounded wait for the answer pulse of the host (0) or engine (1) port
	task automatic wt(input sel);
		integer n;
	begin
		for (n = 0; (sel ? eng_mem_done : lb_ready) !== 1'b1; n = n + 1)
		begin
			if (n == 20)
				tally_and_finish(1'b1);
			@(posedge mclk);
			#1;
		end
	end
	endtask
	task acc(input m, input w, input ia, input [16:0] a, input [15:0] d);
	begin
		@(negedge mclk);
		{lb_mem_sel, lb_reg_sel, lb_rd, lb_wr, lb_intack} = {m, !m, !w && !ia, w, ia};
		lb_addr = a;
		lb_wdata = d;
		wt(1'b0);
		got = lb_rdata;
		@(negedge mclk);
		{lb_mem_sel, lb_reg_sel, lb_rd, lb_wr, lb_intack} = 5'h00;
		repeat (2) @(negedge mclk);
	end
	endtask
	task rst_chk;
	begin
		reset = 1'b1;
		repeat (2) @(negedge mclk);
		reset = 1'b0;
		chk("rst", 16'h0020, {10'h000, bus_controller_mode, rt_addr_out});
		acc(1'b0, 1'b0, 1'b0, 17'h00042, 16'h0000);
		chk("status", 16'h0004, got);
	end
	endtask
	initial
	begin
		rows[0] = {3'h6, 17'h00000, 16'h1234, 16'h0000};
		rows[1] = {3'h4, 17'h00000, 16'h0000, 16'h1234};
		rows[2] = {3'h7, 17'h1FFFE, 16'hABCD, 16'h0000};
		rows[3] = {3'h4, 17'h1FFFE, 16'h0000, 16'hCDAB};
		rows[4] = {3'h5, 17'h1FFFE, 16'h0000, 16'hABCD};
		rows[5] = {3'h2, 17'h0003E, 16'h5A0F, 16'h0000};
		rows[6] = {3'h1, 17'h0003E, 16'h0000, 16'h0F5A};
		rows[7] = {3'h2, 17'h00000, 16'h0011, 16'h0000};
		rst_chk;
		for (i = 0; i < 8; i = i + 1)
		begin
			swap_jumper = rows[i][49];
			acc(rows[i][51], rows[i][50], 1'b0, rows[i][48:32], rows[i][31:16]);
			if (!rows[i][50])
				chk("row", rows[i][15:0], got);
		end
		swap_jumper = 1'b0;
		for (i = 0; i < 4; i = i + 1)
		begin
			cfg = {i[1], i[0], i == 3, i[1], i[0]};
			rta = {i[1:0], ~i[1:0], 1'b1};
			engine_ready = i[0];
			master_reset_in = 1'b1;
			repeat (2) @(negedge mclk);
			master_reset_in = 1'b0;
			acc(1'b0, 1'b0, 1'b0, {16'h0021, i[0]}, 16'h0000);
			chk("status", {12'h000, !i[0], i != 3, i[1], i[0]}, got);
			chk("mode", {13'h0000, i == 0, i[0], i[1]}, {13'h0000, md});
			chk("rt", {9'h000, cfg[4:3], rta}, {9'h000, rtv});
		end
		cfg = 5'h00;
		acc(1'b0, 1'b1, 1'b0, 17'h00000, 16'h00FF);
		acc(1'b0, 1'b0, 1'b0, 17'h00000, 16'h0000);
		chk("locked", 16'h0011, got);
		acc(1'b0, 1'b1, 1'b0, 17'h00042, 16'hFFFF);
		acc(1'b0, 1'b0, 1'b0, 17'h00042, 16'h0000);
		chk("st_wr", 16'h0003, got);
		swap_jumper = 1'b1;
		acc(1'b0, 1'b0, 1'b1, 17'h00000, 16'h0000);
		chk("vector", 16'h005C, {8'h00, got[7:0]});
		swap_jumper = 1'b0;
		fork
			acc(1'b1, 1'b0, 1'b0, 17'h0000A, 16'h0000);
			begin
				@(negedge mclk);
				{eng_mem_req, eng_mem_we, eng_mem_addr, eng_mem_wdata} = {2'h3, 16'h0005, 16'hBEEF};
				wt(1'b1);
				@(negedge mclk);
				eng_mem_req = 1'b0;
			end
		join
		chk("arb", 16'hBEEF, got);
		@(negedge mclk);
		{eng_mem_req, eng_mem_we, eng_mem_addr} = {2'h2, 16'h0005};
		wt(1'b1);
		@(negedge mclk);
		eng_mem_req = 1'b0;
		chk("eng_rd", 16'hBEEF, eng_mem_rdata);
		for (i = 0; i < 2; i = i + 1)
		begin
			{terminal_fail_irq, message_irq} = i[0] ? 2'h2 : 2'h1;
			repeat (3) @(negedge mclk);
			{terminal_fail_irq, message_irq} = 2'h0;
			repeat (4) @(negedge mclk);
		end
		chk("irq", 16'h0006, irq_n);
		chk("inbox", 16'h0002, ibx_n);
		rst_chk;
		tally_and_finish(1'b0);
	end
endmodule // tb_host_side_glue_arbiter
